/* File: src/lcc_pkg.sv */
package lcc_pkg;
  // ---------------------------------------------------------------
  // register map, index form: byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [11:0] LCC_IDX_CTRL_ZERO  = 12'hF00;
  localparam logic [11:0] LCC_IDX_CTRL_ONE   = 12'hF01;
  localparam logic [11:0] LCC_IDX_PULSE_BASE = 12'hF08;
  localparam int          LCC_PULSE_COUNT    = 8;
  localparam int          LCC_ADR_WIDTH      = 14;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LCC_POS_PATTERN_TYPE   = 7;
  localparam int LCC_POS_PATTERN_DEST   = 6;
  localparam int LCC_POS_RX_POWER       = 5;
  localparam int LCC_POS_EQ_LSB         = 0;
  localparam int LCC_POS_RX_TERM        = 7;
  localparam int LCC_POS_TX_TERM        = 6;
  localparam int LCC_POS_TERM_CODE_LSB  = 4;
  localparam int LCC_POS_RX_JITTER      = 3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] LCC_RST_CTRL_ZERO = 8'h00;
  localparam logic [7:0] LCC_RST_CTRL_ONE  = 8'h00;
  localparam logic [7:0] LCC_RST_PULSE     = 8'h00;

  // ---------------------------------------------------------------
  // equalizer code boundaries
  // ---------------------------------------------------------------
  localparam logic [4:0] LCC_EQ_T1_LH_LAST   = 5'h07;
  localparam logic [4:0] LCC_EQ_T1_LH45_LO   = 5'h04;
  localparam logic [4:0] LCC_EQ_T1_SH_FIRST  = 5'h08;
  localparam logic [4:0] LCC_EQ_T1_SH_ARB    = 5'h0D;
  localparam logic [4:0] LCC_EQ_T1_GAIN_LO   = 5'h0E;
  localparam logic [4:0] LCC_EQ_T1_GAIN_ARB  = 5'h13;
  localparam logic [4:0] LCC_EQ_T1_GAIN_LBO  = 5'h14;
  localparam logic [4:0] LCC_EQ_E1_FIRST     = 5'h18;

  typedef enum logic [1:0] {
    LCC_HAUL_LONG  = 2'b00,
    LCC_HAUL_SHORT = 2'b01,
    LCC_HAUL_GAIN  = 2'b10
  } lcc_haul_t;

  typedef enum logic [1:0] {
    LCC_SENS_15DB = 2'b00,
    LCC_SENS_29DB = 2'b01,
    LCC_SENS_36DB = 2'b10,
    LCC_SENS_45DB = 2'b11
  } lcc_sens_t;

  typedef enum logic [1:0] {
    LCC_MEDIA_TP100  = 2'b00,
    LCC_MEDIA_COAX75 = 2'b01,
    LCC_MEDIA_TP120  = 2'b10
  } lcc_media_t;
endpackage

/* File: src/lcc_eq_decode.sv */
`timescale 1ns/1ps
module lcc_eq_decode
  import lcc_pkg::*;
(
  input  wire logic [4:0] code_i,
  output lcc_haul_t       haul_o,
  output lcc_sens_t       sens_o,
  output lcc_media_t      media_o,
  output logic            e1_mode_o,
  output logic            arbitrary_o,
  output logic [1:0]      build_out_o,
  output logic [2:0]      cable_range_o
);
  // ---------------------------------------------------------------
  // equalizer code to line mode
  // ---------------------------------------------------------------
  always_comb begin
    haul_o        = LCC_HAUL_LONG;
    sens_o        = LCC_SENS_36DB;
    media_o       = LCC_MEDIA_TP100;
    e1_mode_o     = 1'b0;
    arbitrary_o   = 1'b0;
    build_out_o   = 2'h0;
    cable_range_o = 3'h0;
    if (code_i <= LCC_EQ_T1_LH_LAST) begin // RQ5
      sens_o      = (code_i >= LCC_EQ_T1_LH45_LO) ? LCC_SENS_45DB : LCC_SENS_36DB;
      build_out_o = code_i[1:0];
    end else if (code_i <= LCC_EQ_T1_SH_ARB) begin // RQ6
      haul_o        = LCC_HAUL_SHORT;
      sens_o        = LCC_SENS_15DB;
      arbitrary_o   = (code_i == LCC_EQ_T1_SH_ARB);
      // the arbitrary code has no cable range of its own
      if (code_i != LCC_EQ_T1_SH_ARB)
        cable_range_o = 3'(code_i - LCC_EQ_T1_SH_FIRST);
    end else if (code_i < LCC_EQ_E1_FIRST) begin // RQ7
      haul_o = LCC_HAUL_GAIN;
      sens_o = LCC_SENS_29DB;
      if (code_i < LCC_EQ_T1_GAIN_ARB)
        cable_range_o = 3'(code_i - LCC_EQ_T1_GAIN_LO);
      arbitrary_o = (code_i == LCC_EQ_T1_GAIN_ARB);
      if (code_i >= LCC_EQ_T1_GAIN_LBO)
        build_out_o = code_i[1:0];
    end else begin // RQ8
      e1_mode_o = 1'b1;
      media_o   = code_i[0] ? LCC_MEDIA_TP120 : LCC_MEDIA_COAX75;
      case (code_i[2:1])
        2'h0:    sens_o = LCC_SENS_36DB;
        2'h1:    sens_o = LCC_SENS_45DB;
        2'h2:    sens_o = LCC_SENS_15DB;
        default: sens_o = LCC_SENS_29DB;
      endcase
      case (code_i[2:1])
        2'h2:    haul_o = LCC_HAUL_SHORT;
        2'h3:    haul_o = LCC_HAUL_GAIN;
        default: haul_o = LCC_HAUL_LONG;
      endcase
    end
  end
endmodule // lcc_eq_decode

/* File: src/lcc_top.sv */
// How it works
// RQ1 - bit 7 of control zero picks 2^15-1 pseudo-random or 2^20-1 quasi-random
// RQ2 - bit 6 of control zero sends pattern to line (0) or receive outputs (1)
// RQ3 - bit 5 of control zero powers receive section; pll stays on when 0
// RQ4 - bits 4..0 of control zero hold equalizer code, reset 00000
// RQ5 - codes 00..07 are T1 long haul, 36/45 dB, four build-outs each
// RQ6 - codes 08..0C T1 short haul cable ranges; 0D short haul arbitrary pulse
// RQ7 - codes 0E..17 T1 gain mode 29 dB: ranges, arbitrary 13, build-outs
// RQ8 - codes 18..1F E1 pairs; even code coax 75, odd twisted pair 120
// RQ9 - arbitrary codes shape pulse from eight segment registers from 0x0f08
// RQ10 - bit 7 of control one selects receive termination; high impedance at reset
// RQ11 - bit 6 of control one selects transmit termination
// RQ12 - bits 5..4 pick 100/110/75/120 ohm when both terminations internal
// RQ13 - bit 3 of control one enables receive jitter attenuator, default off
// RQ14 - fields drive static outputs, effective the cycle after write completes
`timescale 1ns/1ps
module lcc_top
  import lcc_pkg::*;
#(
  parameter int PULSE_SEGMENTS = LCC_PULSE_COUNT
)(
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     cyc_i,
  input  wire logic                     stb_i,
  input  wire logic                     we_i,
  input  wire logic [LCC_ADR_WIDTH-1:0] adr_i,
  input  wire logic [3:0]               sel_i,
  input  wire logic [31:0]              dat_i,
  output logic      [31:0]              dat_o,
  output logic                          ack_o,
  output logic                          pattern_quasi_random_o,
  output logic                          pattern_destination_select_o,
  output logic                          receiver_power_enable_o,
  output logic      [4:0]               equalizer_code_o,
  output logic                          receive_termination_select_o,
  output logic                          transmit_termination_select_o,
  output logic      [1:0]               termination_impedance_code_o,
  output logic                          internal_impedance_valid_o,
  output logic                          receive_jitter_attenuator_enable_o,
  output logic                          e1_mode_o,
  output lcc_haul_t                     haul_mode_o,
  output lcc_sens_t                     receive_sensitivity_o,
  output lcc_media_t                    cable_media_o,
  output logic      [1:0]               transmit_build_out_o,
  output logic      [2:0]               cable_range_o,
  output logic                          arbitrary_pulse_o,
  output logic      [7:0]               pulse_segment_o [PULSE_SEGMENTS]
);
  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  if (PULSE_SEGMENTS != LCC_PULSE_COUNT) begin : g_bad_seg
    $error("pulse segment count must be eight");
  end

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  function automatic logic [11:0] word_index(input logic [LCC_ADR_WIDTH-1:0] a);
    return a[LCC_ADR_WIDTH-1:2];
  endfunction

  logic [11:0] idx;
  logic        req;
  logic        wr_ok;
  logic        hit_zero;
  logic        hit_one;
  logic        hit_seg;
  logic [2:0]  seg_idx;
  logic [11:0] seg_off;

  assign idx      = word_index(adr_i);
  assign req      = cyc_i && stb_i && !ack_o;
  assign wr_ok    = req && we_i && sel_i[0];
  assign hit_zero = (idx == LCC_IDX_CTRL_ZERO);
  assign hit_one  = (idx == LCC_IDX_CTRL_ONE);
  assign seg_off  = idx - LCC_IDX_PULSE_BASE;
  assign hit_seg  = (idx >= LCC_IDX_PULSE_BASE) && (seg_off < 12'(PULSE_SEGMENTS));
  assign seg_idx  = seg_off[2:0];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] ctrl_zero_r;
  logic [7:0] ctrl_one_r;
  logic [7:0] seg_r [PULSE_SEGMENTS];

  // writes land on the edge that raises ack; the field outputs follow one edge later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_zero_r <= LCC_RST_CTRL_ZERO; // RQ4
    end else if (wr_ok && hit_zero) begin
      ctrl_zero_r <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_one_r <= LCC_RST_CTRL_ONE; // RQ10
    end else if (wr_ok && hit_one) begin
      ctrl_one_r <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < PULSE_SEGMENTS; i++) seg_r[i] <= LCC_RST_PULSE;
    end else if (wr_ok && hit_seg) begin
      seg_r[seg_idx] <= dat_i[7:0]; // RQ9
    end
  end

  // one wait-free answer: ack one cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      dat_o <= 32'h0000_0000;
      if (req && !we_i) begin
        if (hit_zero)      dat_o <= {24'h00_0000, ctrl_zero_r};
        else if (hit_one)  dat_o <= {24'h00_0000, ctrl_one_r};
        else if (hit_seg)  dat_o <= {24'h00_0000, seg_r[seg_idx]};
      end
    end
  end

  // ---------------------------------------------------------------
  // equalizer decode
  // ---------------------------------------------------------------
  lcc_haul_t  haul_nxt;
  lcc_sens_t  sens_nxt;
  lcc_media_t media_nxt;
  logic       e1_nxt;
  logic       arb_nxt;
  logic [1:0] lbo_nxt;
  logic [2:0] range_nxt;

  lcc_eq_decode u_eq (
    .code_i        (ctrl_zero_r[LCC_POS_EQ_LSB +: 5]),
    .haul_o        (haul_nxt),
    .sens_o        (sens_nxt),
    .media_o       (media_nxt),
    .e1_mode_o     (e1_nxt),
    .arbitrary_o   (arb_nxt),
    .build_out_o   (lbo_nxt),
    .cable_range_o (range_nxt)
  );

  // ---------------------------------------------------------------
  // static configuration outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pattern_quasi_random_o       <= 1'b0;
      pattern_destination_select_o <= 1'b0;
      receiver_power_enable_o      <= 1'b0;
      equalizer_code_o             <= 5'h00;
    end else begin
      pattern_quasi_random_o       <= ctrl_zero_r[LCC_POS_PATTERN_TYPE]; // RQ1
      pattern_destination_select_o <= ctrl_zero_r[LCC_POS_PATTERN_DEST]; // RQ2
      receiver_power_enable_o      <= ctrl_zero_r[LCC_POS_RX_POWER]; // RQ3
      equalizer_code_o             <= ctrl_zero_r[LCC_POS_EQ_LSB +: 5]; // RQ14
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      receive_termination_select_o       <= 1'b0;
      transmit_termination_select_o      <= 1'b0;
      termination_impedance_code_o       <= 2'h0;
      internal_impedance_valid_o         <= 1'b0;
      receive_jitter_attenuator_enable_o <= 1'b0;
    end else begin
      receive_termination_select_o  <= ctrl_one_r[LCC_POS_RX_TERM]; // RQ10
      transmit_termination_select_o <= ctrl_one_r[LCC_POS_TX_TERM]; // RQ11
      termination_impedance_code_o  <= ctrl_one_r[LCC_POS_TERM_CODE_LSB +: 2]; // RQ12
      // impedance code only matters with both sides internally terminated
      internal_impedance_valid_o    <= ctrl_one_r[LCC_POS_RX_TERM]
                                       && ctrl_one_r[LCC_POS_TX_TERM]; // RQ12
      receive_jitter_attenuator_enable_o <= ctrl_one_r[LCC_POS_RX_JITTER]; // RQ13
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      e1_mode_o             <= 1'b0;
      haul_mode_o           <= LCC_HAUL_LONG;
      receive_sensitivity_o <= LCC_SENS_36DB;
      cable_media_o         <= LCC_MEDIA_TP100;
      transmit_build_out_o  <= 2'h0;
      cable_range_o         <= 3'h0;
      arbitrary_pulse_o     <= 1'b0;
    end else begin
      e1_mode_o             <= e1_nxt; // RQ8
      haul_mode_o           <= haul_nxt; // RQ5
      receive_sensitivity_o <= sens_nxt; // RQ6
      cable_media_o         <= media_nxt; // RQ8
      transmit_build_out_o  <= lbo_nxt; // RQ7
      cable_range_o         <= range_nxt;
      arbitrary_pulse_o     <= arb_nxt; // RQ9
    end
  end

  // segments reach the shaper only while an arbitrary code is active
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < PULSE_SEGMENTS; i++) pulse_segment_o[i] <= LCC_RST_PULSE;
    end else begin
      for (int i = 0; i < PULSE_SEGMENTS; i++)
        pulse_segment_o[i] <= arb_nxt ? seg_r[i] : LCC_RST_PULSE; // RQ9
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_rx_power;
    @(posedge clk_i) disable iff (rst_i)
      (ack_o && $past(we_i && hit_zero && sel_i[0]))
        |=> receiver_power_enable_o == $past(dat_i[LCC_POS_RX_POWER], 2);
  endproperty
  a_rx_power: assert property (p_rx_power) else $error("rx power not following write"); // RQ3

  property p_pattern;
    @(posedge clk_i) disable iff (rst_i)
      ##1 (pattern_quasi_random_o == $past(ctrl_zero_r[LCC_POS_PATTERN_TYPE]))
          && (pattern_destination_select_o == $past(ctrl_zero_r[LCC_POS_PATTERN_DEST]));
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern fields wrong"); // RQ1

  property p_eq_write;
    @(posedge clk_i) disable iff (rst_i)
      (wr_ok && hit_zero) |=> ##1 equalizer_code_o == $past(dat_i[4:0], 2);
  endproperty
  a_eq_write: assert property (p_eq_write) else $error("equalizer code late"); // RQ14

  property p_long_haul;
    @(posedge clk_i) disable iff (rst_i)
      (equalizer_code_o <= LCC_EQ_T1_LH_LAST && $stable(equalizer_code_o))
        |-> haul_mode_o == LCC_HAUL_LONG && !e1_mode_o
            && transmit_build_out_o == equalizer_code_o[1:0];
  endproperty
  a_long_haul: assert property (p_long_haul) else $error("long haul decode wrong"); // RQ5

  property p_short_arb;
    @(posedge clk_i) disable iff (rst_i)
      ($stable(equalizer_code_o) && equalizer_code_o == LCC_EQ_T1_SH_ARB)
        |-> arbitrary_pulse_o && haul_mode_o == LCC_HAUL_SHORT
            && receive_sensitivity_o == LCC_SENS_15DB;
  endproperty
  a_short_arb: assert property (p_short_arb) else $error("short haul arbitrary wrong"); // RQ6

  property p_gain;
    @(posedge clk_i) disable iff (rst_i)
      ($stable(equalizer_code_o) && equalizer_code_o >= LCC_EQ_T1_GAIN_LO
       && equalizer_code_o < LCC_EQ_E1_FIRST)
        |-> receive_sensitivity_o == LCC_SENS_29DB && haul_mode_o == LCC_HAUL_GAIN;
  endproperty
  a_gain: assert property (p_gain) else $error("gain mode decode wrong"); // RQ7

  property p_e1_media;
    @(posedge clk_i) disable iff (rst_i)
      ($stable(equalizer_code_o) && equalizer_code_o >= LCC_EQ_E1_FIRST)
        |-> e1_mode_o && cable_media_o ==
            (equalizer_code_o[0] ? LCC_MEDIA_TP120 : LCC_MEDIA_COAX75);
  endproperty
  a_e1_media: assert property (p_e1_media) else $error("e1 media wrong"); // RQ8

  property p_term;
    @(posedge clk_i) disable iff (rst_i)
      ##1 internal_impedance_valid_o == (receive_termination_select_o
                                         && transmit_termination_select_o);
  endproperty
  a_term: assert property (p_term) else $error("impedance valid mismatch"); // RQ12

  property p_jitter;
    @(posedge clk_i) disable iff (rst_i)
      (wr_ok && hit_one) |=> ##1 receive_jitter_attenuator_enable_o == $past(dat_i[3], 2)
        && transmit_termination_select_o == $past(dat_i[6], 2);
  endproperty
  a_jitter: assert property (p_jitter) else $error("control one fields late"); // RQ13

  property p_rx_term_reset;
    @(posedge clk_i) $fell(rst_i) |-> !receive_termination_select_o;
  endproperty
  a_rx_term_reset: assert property (p_rx_term_reset) else $error("rx not high impedance"); // RQ10

  property p_tx_term;
    @(posedge clk_i) disable iff (rst_i)
      ##1 transmit_termination_select_o == $past(ctrl_one_r[LCC_POS_TX_TERM]);
  endproperty
  a_tx_term: assert property (p_tx_term) else $error("tx termination wrong"); // RQ11

  property p_eq_reset;
    @(posedge clk_i) $fell(rst_i) |-> equalizer_code_o == 5'h00;
  endproperty
  a_eq_reset: assert property (p_eq_reset) else $error("equalizer not reset"); // RQ4

  property p_seg_gate;
    @(posedge clk_i) disable iff (rst_i)
      !arbitrary_pulse_o && $stable(arbitrary_pulse_o) |-> pulse_segment_o[0] == 8'h00;
  endproperty
  a_seg_gate: assert property (p_seg_gate) else $error("segments leak"); // RQ9

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
      ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long"); // RQ14

  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered"); // RQ14

  property p_read_idle;
    @(posedge clk_i) disable iff (rst_i)
      !ack_o |-> dat_o == 32'h0000_0000;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside ack"); // RQ14

  property p_read_upper;
    @(posedge clk_i) disable iff (rst_i)
      ack_o |-> dat_o[31:8] == 24'h00_0000;
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("read data upper bits set"); // RQ14

  property p_lane_refuse;
    @(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o && we_i && !sel_i[0])
        |=> $stable(ctrl_zero_r) && $stable(ctrl_one_r);
  endproperty
  a_lane_refuse: assert property (p_lane_refuse) else $error("unselected lane written"); // RQ4

  property p_one_write;
    @(posedge clk_i) disable iff (rst_i)
      (wr_ok && hit_one) |=> ctrl_one_r == $past(dat_i[7:0]);
  endproperty
  a_one_write: assert property (p_one_write) else $error("control one write lost"); // RQ10

  property p_off_reset;
    @(posedge clk_i)
      $fell(rst_i) |-> !receive_jitter_attenuator_enable_o && !receiver_power_enable_o
        && !transmit_termination_select_o;
  endproperty
  a_off_reset: assert property (p_off_reset) else $error("enables not off after reset"); // RQ13
endmodule // lcc_top

/* File: test/tb.sv */
`timescale 1ns/1ps
module tb;
  import lcc_pkg::*;
  typedef struct packed { logic [31:0] val; logic [31:0] msk; } lcc_note_t;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic                     clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [LCC_ADR_WIDTH-1:0] adr_i;
  logic [3:0]               sel_i;
  logic [31:0]              dat_i, dat_o;
  logic                     pat_qr, pat_dst, rx_pwr, rx_term, tx_term, imp_vld, rx_ja, e1, arb;
  logic [4:0]               eq_code;
  logic [1:0]               term_code, bo;
  logic [2:0]               rng;
  lcc_haul_t                haul;
  lcc_sens_t                sens;
  lcc_media_t               media;
  logic [7:0]               seg [LCC_PULSE_COUNT];
  logic [7:0]               seg_w [LCC_PULSE_COUNT];
  lcc_note_t                notes [$];
  lcc_note_t                note;
  int                       bad_count, n_checks, cycles;
  logic [7:0]               r0, r1;

  lcc_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pattern_quasi_random_o(pat_qr), .pattern_destination_select_o(pat_dst),
    .receiver_power_enable_o(rx_pwr), .equalizer_code_o(eq_code),
    .receive_termination_select_o(rx_term), .transmit_termination_select_o(tx_term),
    .termination_impedance_code_o(term_code), .internal_impedance_valid_o(imp_vld),
    .receive_jitter_attenuator_enable_o(rx_ja), .e1_mode_o(e1), .haul_mode_o(haul),
    .receive_sensitivity_o(sens), .cable_media_o(media), .transmit_build_out_o(bo),
    .cable_range_o(rng), .arbitrary_pulse_o(arb), .pulse_segment_o(seg));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // reporting and comparison
  // ---------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // a runaway wait must still reach the verdict
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      $display("CHECK FAILED t=%0t run did not finish", $time);
      test_done();
    end
  end

  // read data is judged only in the ack cycle, against the oldest note
  always @(posedge clk_i) begin
    if (ack_o === 1'b1) begin
      if (notes.size() == 0) begin
        chk(32'h1, 32'h0, "ack with no request");
      end else begin
        note = notes.pop_front();
        chk(dat_o & note.msk, note.val & note.msk, "read data");
      end
    end
  end

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  task automatic wb_cycle(input logic w, input logic [11:0] idx, input logic [3:0] sel,
                          input logic [31:0] wd, input lcc_note_t n);
    int guard;
    guard = 0;
    @(posedge clk_i);
    notes.push_back(n);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= sel;
    dat_i <= wd;
    do begin
      @(posedge clk_i);
      guard++;
    end while (ack_o !== 1'b1);
    chk(32'(guard), 32'h2, "ack latency");
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    dat_i <= $urandom;
    // one cycle more: config outputs follow the register one edge later
    @(posedge clk_i);
    #1;
  endtask

  task automatic wb_write(input logic [11:0] idx, input logic [7:0] d, input logic [3:0] sel);
    wb_cycle(1'b1, idx, sel, {24'($urandom), d}, '{32'h0, 32'hFFFF_FFFF});
  endtask

  task automatic wb_read(input logic [11:0] idx, input logic [7:0] e, input logic [7:0] m);
    wb_cycle(1'b0, idx, 4'hF, $urandom, '{{24'h0, e}, {24'hFF_FFFF, m}});
  endtask

  // ---------------------------------------------------------------
  // expected decode of the equalizer code
  // ---------------------------------------------------------------
  function automatic logic [12:0] exp_dec(input logic [4:0] c);
    lcc_haul_t  h;
    lcc_sens_t  s;
    lcc_media_t m;
    logic [1:0] b;
    logic [2:0] r;
    h = LCC_HAUL_LONG;
    s = LCC_SENS_36DB;
    m = LCC_MEDIA_TP100;
    b = 2'h0;
    r = 3'h0;
    if (c >= 5'h18) begin
      m = c[0] ? LCC_MEDIA_TP120 : LCC_MEDIA_COAX75;
      case (c[2:1])
        2'b00: s = LCC_SENS_36DB;
        2'b01: s = LCC_SENS_45DB;
        2'b10: s = LCC_SENS_15DB;
        default: s = LCC_SENS_29DB;
      endcase
      if (c[2:1] == 2'b10) h = LCC_HAUL_SHORT;
      if (c[2:1] == 2'b11) h = LCC_HAUL_GAIN;
    end else if (c <= 5'h07) begin
      s = c[2] ? LCC_SENS_45DB : LCC_SENS_36DB;
      b = c[1:0];
    end else if (c <= 5'h0D) begin
      h = LCC_HAUL_SHORT;
      s = LCC_SENS_15DB;
      if (c != 5'h0D) r = 3'(c - 5'h08);
    end else begin
      h = LCC_HAUL_GAIN;
      s = LCC_SENS_29DB;
      if (c <= 5'h12) r = 3'(c - 5'h0E);
      if (c >= 5'h14) b = c[1:0];
    end
    return {h, s, m, c >= 5'h18, c == 5'h0D || c == 5'h13, b, r};
  endfunction

  task automatic chk_cfg;
    chk({pat_qr, pat_dst, rx_pwr}, {29'h0, r0[7:5]}, "pattern and receiver");
    chk(eq_code, r0[4:0], "equalizer code");
    chk({haul, sens, media, e1, arb, bo, rng}, exp_dec(r0[4:0]), "decode");
    chk({rx_term, tx_term, term_code}, r1[7:4], "termination");
    chk(imp_vld, r1[7] & r1[6], "internal impedance");
    chk(rx_ja, r1[3], "jitter attenuator");
    for (int i = 0; i < LCC_PULSE_COUNT; i++) begin
      chk(seg[i], (r0[4:0] == 5'h0D || r0[4:0] == 5'h13) ? seg_w[i] : 8'h00, "segment");
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hB8ADFEC8));
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    rst_i = 1'b1;
    r0 = 8'h00;
    r1 = 8'h00;
    foreach (seg_w[i]) seg_w[i] = 8'h00;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk_cfg();
    wb_read(LCC_IDX_CTRL_ZERO, 8'h00, 8'hFF);
    wb_read(LCC_IDX_CTRL_ONE, 8'h00, 8'hF8);
    // segment registers read back while no arbitrary code is active
    for (int i = 0; i < LCC_PULSE_COUNT; i++) begin
      seg_w[i] = 8'($urandom);
      wb_write(LCC_IDX_PULSE_BASE + 12'(i), seg_w[i], {3'($urandom), 1'b1});
      wb_read(LCC_IDX_PULSE_BASE + 12'(i), seg_w[i], 8'hFF);
    end
    // every equalizer code, with random upper control bits
    for (int c = 0; c < 32; c++) begin
      r0 = {3'($urandom), 5'(c)};
      wb_write(LCC_IDX_CTRL_ZERO, r0, 4'hF);
      chk_cfg();
      wb_read(LCC_IDX_CTRL_ZERO, r0, 8'hFF);
    end
    // termination, including both internal at once
    for (int k = 0; k < 12; k++) begin
      r1 = (k < 4) ? {2'b11, 2'(k), 4'h8} : 8'($urandom);
      wb_write(LCC_IDX_CTRL_ONE, r1, 4'hF);
      chk_cfg();
      wb_read(LCC_IDX_CTRL_ONE, r1, 8'hF8);
    end
    // lane zero not selected: the write must not land
    wb_write(LCC_IDX_CTRL_ZERO, ~r0, 4'hE);
    wb_read(LCC_IDX_CTRL_ZERO, r0, 8'hFF);
    // unmapped places: acked, read as zero, writes lost
    wb_write(12'hF02, 8'hFF, 4'hF);
    wb_read(12'hF02, 8'h00, 8'hFF);
    wb_read(12'h000, 8'h00, 8'hFF);
    chk_cfg();
    // arbitrary shaping from the other group, then a second reset
    r0 = 8'h13;
    wb_write(LCC_IDX_CTRL_ZERO, r0, 4'h1);
    chk_cfg();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    r0 = 8'h00;
    r1 = 8'h00;
    foreach (seg_w[i]) seg_w[i] = 8'h00;
    chk_cfg();
    wb_read(LCC_IDX_CTRL_ONE, 8'h00, 8'hF8);
    wb_read(LCC_IDX_PULSE_BASE, 8'h00, 8'hFF);
    repeat (3) @(posedge clk_i);
    chk(notes.size(), 32'h0, "every request acked");
    test_done();
  end
endmodule // tb
